// ---- hw/icc_pkg.sv ----
package icc_pkg;
    localparam int ICC_AW = 4;
    localparam int ICC_DW = 32;
    localparam int ICC_NEXT = 5;
    localparam int ICC_GPW = 3;
    // register offsets
    localparam logic [3:0] ICC_OFS_CTRL = 4'h0;
    localparam logic [3:0] ICC_OFS_STAT = 4'h4;
    localparam logic [3:0] ICC_OFS_MASK = 4'h8;
    localparam logic [3:0] ICC_OFS_RAW = 4'hc;
    // control field positions
    localparam int ICC_BIT_SHADOW = 16;
    localparam int ICC_BIT_MULTI_VECTOR_SEL = 12;
    localparam int ICC_BIT_TPC_LO = 8;
    localparam int ICC_BIT_POL_LO = 0;
    // writable bits of the control register
    localparam logic [31:0] ICC_CTRL_WMASK = 32'h0001_171f;
    localparam logic [31:0] ICC_CTRL_RESET = 32'h0000_0000;
    localparam logic [2:0] ICC_TPC_OFF = 3'h0;
    // cycles until all three sync stages hold real pin levels
    localparam logic [1:0] ICC_SYNC_SETTLE = 2'h3;
endpackage

// ---- hw/icc_interrupt_control.sv ----
// Overview of operation
// (RULE1) shadow bit set gives single-vector shadow set
// (RULE2) vector bit selects multi or single vector
// (RULE3) nonzero threshold n: priority <= n starts timer
// (RULE4) threshold zero disables proximity timer start
// (RULE5) per-input polarity bit: 1 rising, 0 falling
// (RULE6) unimplemented control bits read as zero
// (RULE7) synchronise inputs, pulse once per edge
//
// The plain strobed port and the register addresses were left to the implementer.
module icc_interrupt_control
    import icc_pkg::*;
#(
    parameter int NEXT = ICC_NEXT
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [ICC_AW-1:0] addr_in,
    input wire logic [ICC_DW-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [ICC_DW-1:0] rdata_out,
    input wire logic [NEXT-1:0] ext_irq_in,
    input wire logic [ICC_GPW-1:0] req_group_prio_in,
    input wire logic req_valid_in,
    output logic prox_timer_start_out,
    output logic multi_vector_sel_out,
    output logic single_vector_shadow_sel_out,
    output logic use_shadow_out,
    output logic [NEXT-1:0] ext_irq_req_out,
    output logic irq_out
);
    logic [31:0] ctrl_q;
    logic [NEXT-1:0] stat_q;
    logic [NEXT-1:0] mask_q;
    logic [NEXT-1:0] s1_q, s2_q, s3_q;
    logic [NEXT-1:0] lvl_q;
    logic [NEXT-1:0] req_q;
    logic [ICC_DW-1:0] rdata_q;
    logic prox_q;
    logic [1:0] settle_q;

    function automatic logic icc_hit(input logic [ICC_AW-1:0] ad, input logic [3:0] ofs);
        icc_hit = (ad == ofs);
    endfunction

    wire wr_ctrl = wr_in && icc_hit(addr_in, ICC_OFS_CTRL);
    wire wr_stat = wr_in && icc_hit(addr_in, ICC_OFS_STAT);
    wire wr_mask = wr_in && icc_hit(addr_in, ICC_OFS_MASK);
    wire [2:0] threshold = ctrl_q[ICC_BIT_TPC_LO +: 3];
    wire [NEXT-1:0] pol = ctrl_q[ICC_BIT_POL_LO +: NEXT];

    // no edges until the chain is full, so a pin idling high after
    // reset does not look like a rising edge
    wire settled = (settle_q == ICC_SYNC_SETTLE);
    wire [1:0] settle_d = settled ? settle_q : settle_q + 2'h1;

    // (RULE7) a change counts once stage two and three agree
    wire [NEXT-1:0] agree = ~(s2_q ^ s3_q);
    // while settling the level tracks what stage three is about to take
    wire [NEXT-1:0] lvl_d = settled ? ((agree & s3_q) | (~agree & lvl_q)) : s2_q;
    wire [NEXT-1:0] edge_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NEXT; gi = gi + 1) begin : g_ext
            wire rise = agree[gi] && s3_q[gi] && !lvl_q[gi];
            wire fall = agree[gi] && !s3_q[gi] && lvl_q[gi];
            // (RULE5) polarity chooses the edge
            assign edge_hit[gi] = settled && ((pol[gi] && rise) || (!pol[gi] && fall));
        end
    endgenerate

    // (RULE3) (RULE4) threshold gate, zero disables
    wire prox_d = req_valid_in && (threshold != ICC_TPC_OFF)
                  && (req_group_prio_in <= threshold);

    // (RULE6) unmapped control bits stay zero via mask
    logic [ICC_DW-1:0] rmux;
    always_comb begin
        case (addr_in)
            ICC_OFS_CTRL: rmux = ctrl_q & ICC_CTRL_WMASK;
            ICC_OFS_STAT: rmux = {{(ICC_DW-NEXT){1'b0}}, stat_q};
            ICC_OFS_MASK: rmux = {{(ICC_DW-NEXT){1'b0}}, mask_q};
            ICC_OFS_RAW: rmux = {{(ICC_DW-NEXT){1'b0}}, s3_q};
            default: rmux = '0;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            ctrl_q <= ICC_CTRL_RESET;
            mask_q <= '0;
            stat_q <= '0;
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
            settle_q <= '0;
            req_q <= '0;
            prox_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata_in & ICC_CTRL_WMASK;
            end
            if (wr_mask) begin
                mask_q <= wdata_in[NEXT-1:0];
            end
            // set wins over write-one-to-clear
            stat_q <= (stat_q & ~(wr_stat ? wdata_in[NEXT-1:0] : '0)) | edge_hit;
            s1_q <= ext_irq_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            settle_q <= settle_d;
            req_q <= edge_hit;
            prox_q <= prox_d;
            rdata_q <= rd_in ? rmux : '0;
        end
    end

    assign rdata_out = rdata_q;
    assign ext_irq_req_out = req_q;
    assign prox_timer_start_out = prox_q;
    // (RULE2) vector mode out
    assign multi_vector_sel_out = ctrl_q[ICC_BIT_MULTI_VECTOR_SEL];
    // (RULE1) shadow select follows the bit; use_shadow_out only in single-vector mode
    assign single_vector_shadow_sel_out = ctrl_q[ICC_BIT_SHADOW];
    assign use_shadow_out = ctrl_q[ICC_BIT_SHADOW] && !ctrl_q[ICC_BIT_MULTI_VECTOR_SEL];
    assign irq_out = |(stat_q & mask_q);

    property p_shadow; // (RULE1)
        @(posedge mclk_in) disable iff (!nrst_in)
        wr_ctrl |=> (single_vector_shadow_sel_out == $past(wdata_in[ICC_BIT_SHADOW]))
            && (use_shadow_out == ($past(wdata_in[ICC_BIT_SHADOW])
            && !$past(wdata_in[ICC_BIT_MULTI_VECTOR_SEL])));
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow select wrong");

    property p_multi_vector_sel; // (RULE2)
        @(posedge mclk_in) disable iff (!nrst_in)
        wr_ctrl |=> multi_vector_sel_out == $past(wdata_in[ICC_BIT_MULTI_VECTOR_SEL]);
    endproperty
    a_multi_vector_sel: assert property (p_multi_vector_sel) else $error("vector mode not written");

    property p_prox; // (RULE3)
        @(posedge mclk_in) disable iff (!nrst_in)
        (req_valid_in && threshold != 3'h0 && req_group_prio_in <= threshold)
            |=> prox_timer_start_out;
    endproperty
    a_prox: assert property (p_prox) else $error("proximity start missed");

    property p_prox_off; // (RULE4)
        @(posedge mclk_in) disable iff (!nrst_in)
        (threshold == 3'h0 || !req_valid_in) |=> !prox_timer_start_out;
    endproperty
    a_prox_off: assert property (p_prox_off) else $error("proximity start while off");

    property p_edge; // (RULE5)
        @(posedge mclk_in) disable iff (!nrst_in)
        (settled && pol[0] && s2_q[0] && s3_q[0] && !lvl_q[0]) |=> ext_irq_req_out[0];
    endproperty
    a_edge: assert property (p_edge) else $error("rising edge missed");

    property p_rsvd; // (RULE6)
        @(posedge mclk_in) disable iff (!nrst_in)
        (rd_in && addr_in == ICC_OFS_CTRL) |=> (rdata_out & ~ICC_CTRL_WMASK) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

    property p_pulse; // (RULE7)
        @(posedge mclk_in) disable iff (!nrst_in)
        ext_irq_req_out[0] |=> !ext_irq_req_out[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("request longer than one cycle");

    property p_sticky;
        @(posedge mclk_in) disable iff (!nrst_in)
        ext_irq_req_out[0] |-> stat_q[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status not set");

    property p_edge_fall; // (RULE5)
        @(posedge mclk_in) disable iff (!nrst_in)
        (settled && !pol[0] && !s2_q[0] && !s3_q[0] && lvl_q[0]) |=> ext_irq_req_out[0];
    endproperty
    a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");

    property p_edge_wrong; // (RULE5)
        @(posedge mclk_in) disable iff (!nrst_in)
        (pol[0] && lvl_q[0] && !s3_q[0]) |=> !ext_irq_req_out[0];
    endproperty
    a_edge_wrong: assert property (p_edge_wrong) else $error("request on wrong edge");

    property p_prox_upper; // (RULE3)
        @(posedge mclk_in) disable iff (!nrst_in)
        (req_valid_in && req_group_prio_in > threshold) |=> !prox_timer_start_out;
    endproperty
    a_prox_upper: assert property (p_prox_upper) else $error("start above threshold");

    property p_w1c;
        @(posedge mclk_in) disable iff (!nrst_in)
        (wr_stat && wdata_in[0] && !edge_hit[0]) |=> !stat_q[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("status not cleared");

    property p_set_wins;
        @(posedge mclk_in) disable iff (!nrst_in)
        edge_hit[0] |=> stat_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status set lost");

    property p_irq_masked;
        @(posedge mclk_in) disable iff (!nrst_in)
        (wr_mask && wdata_in[NEXT-1:0] == '0) |=> !irq_out;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while all masked");

    property p_rd_idle;
        @(posedge mclk_in) disable iff (!nrst_in)
        !rd_in |=> rdata_out == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

    property p_raw; // (RULE7)
        @(posedge mclk_in) disable iff (!nrst_in)
        (rd_in && addr_in == ICC_OFS_RAW)
            |=> rdata_out == {{(ICC_DW-NEXT){1'b0}}, $past(s3_q)};
    endproperty
    a_raw: assert property (p_raw) else $error("raw pin levels wrong");
endmodule

// ---- bench/icc_cpu_model.sv ----
// core side: counts proximity timer starts it is handed
module icc_cpu_model (
    input wire logic mclk_in,
    input wire logic start_in,
    output int starts_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int count_q = 0;
    always @(posedge mclk_in) if (start_in) count_q <= count_q + 1;
    assign starts_out = count_q;
endmodule

// ---- bench/tb_icc_interrupt_control.sv ----
module tb_icc_interrupt_control;
    import icc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, rv = 0, ts, mv, ss, us, irq;
    logic [3:0] a = '0;
    logic [31:0] wd = '0, d;
    logic [4:0] x = '0, q;
    logic [2:0] p = '0;
    int error_cnt = 0, comparisons = 0, cyc = 0, n;
    always #50 clk = ~clk;
    icc_interrupt_control u_icc_interrupt_control (.mclk_in(clk), .nrst_in(nrst),
        .addr_in(a), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(d), .ext_irq_in(x),
        .req_group_prio_in(p), .req_valid_in(rv), .prox_timer_start_out(ts),
        .multi_vector_sel_out(mv), .single_vector_shadow_sel_out(ss), .use_shadow_out(us),
        .ext_irq_req_out(q), .irq_out(irq));
    icc_cpu_model u_icc_cpu_model (.mclk_in(clk), .start_in(ts), .starts_out(n));
    task chk(input string s, input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", s, e, v);
        end
    endtask
    task wr32(input logic [3:0] ad, input logic [31:0] v);
        @(posedge clk) begin wr <= 1; a <= ad; wd <= v; end
        @(posedge clk) wr <= 0;
        #1;
    endtask
    task rd32(input logic [3:0] ad, output logic [31:0] v);
        @(posedge clk) begin rd <= 1; a <= ad; end
        @(posedge clk) rd <= 0;
        #1 v = d;
    endtask
    task t_regs;
        logic [31:0] v;
        rd32(ICC_OFS_CTRL, v);
        chk("ctrl reset", 0, v);
        wr32(ICC_OFS_CTRL, '1);
        rd32(ICC_OFS_CTRL, v);
        chk("ctrl", 32'h0001171f, v);
        chk("sel", 3'b110, {mv, ss, us});
        wr32(ICC_OFS_CTRL, 32'h00010000);
        chk("sel", 3'b011, {mv, ss, us});
        rd32(4'h2, v);
        chk("unmapped", 0, v);
        @(posedge clk) x <= 5'h0a;
        repeat (5) @(posedge clk);
        wr32(ICC_OFS_RAW, '1);
        rd32(ICC_OFS_RAW, v);
        chk("raw pins", 32'h0a, v);
        @(posedge clk) x <= 5'h00;
        repeat (5) @(posedge clk);
        $display("test regs done");
    endtask
    task t_prox;
        int m, e;
        m = n;
        e = 0;
        for (int t = 0; t < 8; t++) begin
            wr32(ICC_OFS_CTRL, 32'(t) << 8);
            for (int g = 0; g < 8; g++) begin
                @(posedge clk) begin rv <= 1; p <= 3'(g); end
                @(posedge clk) rv <= 0;
                e += (t != 0 && g <= t);
                #1 chk("start", (t != 0 && g <= t), ts);
            end
        end
        @(posedge clk);
        #1 chk("core starts", e, n - m);
        $display("test prox done");
    endtask
    // pin flip, then one full edge pipeline of pulses counted
    task pulse(input int i, input int e);
        int c;
        c = 0;
        @(posedge clk) x[i] <= ~x[i];
        repeat (8) @(posedge clk) #1 if (q[i] === 1'b1) c++;
        chk("edge req", e, c);
    endtask
    task t_edge;
        logic [31:0] v;
        wr32(ICC_OFS_MASK, 32'h1f);
        for (int pol = 1; pol >= 0; pol--) begin
            wr32(ICC_OFS_CTRL, pol ? 32'h1f : 32'h0);
            for (int i = 0; i < 5; i++) begin
                pulse(i, pol);
                pulse(i, !pol);
            end
        end
        chk("irq", 1, irq);
        rd32(ICC_OFS_STAT, v);
        chk("status", 32'h1f, v);
        wr32(ICC_OFS_MASK, 0);
        chk("irq masked", 0, irq);
        wr32(ICC_OFS_MASK, 32'h1f);
        wr32(ICC_OFS_STAT, 32'h1f);
        chk("irq cleared", 0, irq);
        $display("test edge done");
    endtask
    task t_reset;
        logic [31:0] v;
        wr32(ICC_OFS_CTRL, '1);
        wr32(ICC_OFS_MASK, 32'h1f);
        @(posedge clk) nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        #1 chk("outs after reset", 0, {mv, ss, us, irq, ts, q});
        rd32(ICC_OFS_CTRL, v);
        chk("ctrl after reset", 0, v);
        rd32(ICC_OFS_MASK, v);
        chk("mask after reset", 0, v);
        $display("test reset done");
    endtask
    task wrap_up;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            wrap_up;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1;
        t_regs;
        t_prox;
        t_edge;
        t_reset;
        wrap_up;
    end
endmodule
